// [core/opr_pin_drv.sv]
// Pin driver: turns stored levels into pad output and enable.
// Assumes direction comes from same-clock configuration logic.
`timescale 1ns/1ps
module opr_pin_drv (
    input  wire logic clk_i,
    input  wire logic rst_i,
    opr_pin_if.drv    pins
);
    logic [5:0] out_ff;
    logic [5:0] oe_ff;

    // ==========================================================
    // Drive
    // A pin not set as output is never driven, and its registered output level is forced low as well.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_ff <= opr_pkg::OPR_RST_LEVELS;
            oe_ff  <= 6'h00;
        end else begin
            oe_ff  <= pins.dir_out;
            out_ff <= pins.level & pins.dir_out;
        end
    end

    assign pins.pin_out = out_ff;
    assign pins.pin_oe  = oe_ff;

    // ==========================================================
    // Checks
    a_undriven_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (out_ff & ~oe_ff) == 6'h00)
        else $error("pin output high while not enabled");
    a_level_reaches_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ($past(pins.dir_out) == oe_ff) && (out_ff == ($past(pins.level) & oe_ff)))
        else $error("pin level does not follow stored level");
endmodule

// [core/opr_pin_if.sv]
// Carrier between the register slice and its pin driver.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface opr_pin_if;
    logic [5:0] level;
    logic [5:0] dir_out;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    modport regs (output level, output dir_out, input pin_out, input pin_oe);
    modport drv  (input level, input dir_out, output pin_out, output pin_oe);
endinterface

// [core/opr_pkg.sv]
// Constants for the OTP program control and pin output level register slice.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package opr_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam logic [11:0] OPR_IDX_PROG_CTRL = 12'h107;
    localparam logic [11:0] OPR_IDX_PIN_OUT   = 12'h108;
    localparam logic [13:0] OPR_ADR_PROG_CTRL = {OPR_IDX_PROG_CTRL, 2'h0};
    localparam logic [13:0] OPR_ADR_PIN_OUT   = {OPR_IDX_PIN_OUT, 2'h0};
    // ==========================================================
    // Field positions and widths
    localparam int          OPR_BIT_TRIGGER   = 0;
    localparam int          OPR_BIT_PAGE      = 1;
    localparam int          OPR_PIN_W         = 6;
    // ==========================================================
    // Values after reset
    localparam logic        OPR_RST_PAGE      = 1'h0;
    localparam logic [5:0]  OPR_RST_LEVELS    = 6'h00;
    localparam logic [31:0] OPR_RD_ZERO       = 32'h0000_0000;
endpackage

// [core/opr_regs.sv]
// OTP program control and pin output level registers on classic Wishbone.
// Assumes unlock status and pin direction come from same-clock device logic.
`timescale 1ns/1ps
module opr_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [13:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        unlock_one_ok_i,
    input  wire logic        unlock_two_ok_i,
    input  wire logic [5:0]  pin_dir_out_i,
    output logic             prog_start_o,
    output logic             prog_page_o,
    output logic [5:0]       pin_out_o,
    output logic [5:0]       pin_oe_o
);
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        page_ff;
    logic [5:0]  level_ff;
    logic        start_ff;
    logic        start_page_ff;
    logic        req;
    logic        wr_lane0;
    logic        hit_ctrl;
    logic        hit_pins;
    logic [31:0] nxt_dat;

    opr_pin_if pins ();

    // ==========================================================
    // Decode helper
    // The full 14-bit compare keeps aliases of both registers out of the map.
    function automatic logic opr_hit(input logic [13:0] adr, input logic [13:0] target);
        return adr == target;
    endfunction

    // ==========================================================
    // Bus decode
    // One wait state: the answer is registered so read data and ack leave flip-flops.
    assign req      = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    assign hit_ctrl = opr_hit(wb_adr_i, opr_pkg::OPR_ADR_PROG_CTRL);
    assign hit_pins = opr_hit(wb_adr_i, opr_pkg::OPR_ADR_PIN_OUT);

    always_comb begin
        nxt_dat = opr_pkg::OPR_RD_ZERO;
        if (hit_ctrl) begin
            nxt_dat[opr_pkg::OPR_BIT_PAGE] = page_ff;
        end else if (hit_pins) begin
            nxt_dat[opr_pkg::OPR_PIN_W-1:0] = level_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= opr_pkg::OPR_RD_ZERO;
        end else begin
            ack_ff <= req;
            dat_ff <= req ? nxt_dat : opr_pkg::OPR_RD_ZERO;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_ff  <= opr_pkg::OPR_RST_PAGE;
            level_ff <= opr_pkg::OPR_RST_LEVELS;
        end else begin
            if (wr_lane0 && hit_ctrl) begin
                page_ff <= wb_dat_i[opr_pkg::OPR_BIT_PAGE];
            end
            if (wr_lane0 && hit_pins) begin
                level_ff <= wb_dat_i[opr_pkg::OPR_PIN_W-1:0];
            end
        end
    end

    // ==========================================================
    // Program trigger
    // The trigger is never stored: a refused or finished request leaves nothing to read back.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_ff      <= 1'b0;
            start_page_ff <= opr_pkg::OPR_RST_PAGE;
        end else begin
            start_ff <= wr_lane0 && hit_ctrl && wb_dat_i[opr_pkg::OPR_BIT_TRIGGER]
                        && unlock_one_ok_i && unlock_two_ok_i;
            if (wr_lane0 && hit_ctrl) begin
                start_page_ff <= wb_dat_i[opr_pkg::OPR_BIT_PAGE];
            end
        end
    end

    // ==========================================================
    // Pins
    assign pins.level   = level_ff;
    assign pins.dir_out = pin_dir_out_i;

    opr_pin_drv u_drv (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pins  (pins)
    );

    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = dat_ff;
    assign prog_start_o = start_ff;
    assign prog_page_o  = start_page_ff;
    assign pin_out_o    = pins.pin_out;
    assign pin_oe_o     = pins.pin_oe;

    // ==========================================================
    // Checks
    a_ctrl_read_value: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_ctrl) |=> (wb_ack_o && wb_dat_o == {30'h0, $past(page_ff), 1'b0}))
        else $error("control register read value wrong");
    a_page_mapping: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_start_o |-> (prog_page_o == $past(wb_dat_i[1])))
        else $error("programmed page differs from written select");
    a_unlock_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_start_o |-> $past(unlock_one_ok_i && unlock_two_ok_i))
        else $error("programming started while locked");
    a_trigger_fires: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_ctrl && wb_dat_i[0] && unlock_one_ok_i && unlock_two_ok_i)
        |=> prog_start_o ##1 !prog_start_o)
        else $error("trigger did not pulse once");
    a_trigger_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_ctrl) |=> !wb_dat_o[0])
        else $error("trigger bit read back as one");
    a_pin_write_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_pins) |=> (level_ff == $past(wb_dat_i[5:0])))
        else $error("pin level register did not hold written value");
    a_pin_read_value: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_pins) |=> (wb_ack_o && wb_dat_o == {26'h0, $past(level_ff)}))
        else $error("pin level register read value wrong");
    a_level_to_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_pins) ##1 1'b1
        |=> (pin_out_o == ($past(level_ff) & $past(pin_dir_out_i))))
        else $error("pin does not show written level");
    a_pin_gated_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (pin_out_o & ~pin_oe_o) == 6'h00)
        else $error("disabled pin driven high");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> (wb_dat_o[31:6] == 26'h0))
        else $error("reserved bits read nonzero");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // ==========================================================
    // Checks: bus answer
    // The answer is fixed at one cycle, so a host may rely on it without a timeout.
    a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_idle_data_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == opr_pkg::OPR_RD_ZERO))
        else $error("read data not zero outside ack");
    a_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && !hit_ctrl && !hit_pins) |=> (wb_dat_o == opr_pkg::OPR_RD_ZERO))
        else $error("unmapped read returned data");
    a_sel_gates_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && wb_we_i && !wb_sel_i[0]) |=> ($stable(level_ff) && $stable(page_ff)))
        else $error("write without lane zero changed a register");

    // ==========================================================
    // Checks: program trigger
    // A start pulse may only come from an accepted control write with the trigger set.
    a_page_store: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_ctrl) |=> (page_ff == $past(wb_dat_i[opr_pkg::OPR_BIT_PAGE])))
        else $error("page select not stored");
    a_page_held: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_lane0 && hit_ctrl) |=> ($stable(prog_page_o) && $stable(page_ff)))
        else $error("page select changed without a control write");
    a_locked_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_ctrl && !(unlock_one_ok_i && unlock_two_ok_i)) |=> !prog_start_o)
        else $error("locked trigger write started programming");
    a_read_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i) |=> !prog_start_o)
        else $error("read started programming");
    a_start_needs_write: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_start_o |-> $past(wr_lane0 && hit_ctrl && wb_dat_i[0]))
        else $error("start pulse without a trigger write");
    a_start_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_start_o |=> !prog_start_o)
        else $error("start pulse longer than one cycle");

    // ==========================================================
    // Checks: pin levels
    // Pins lag the level register and the direction by one cycle through the driver.
    a_level_held: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_lane0 && hit_pins) |=> $stable(level_ff))
        else $error("pin level changed without a pin write");
    a_oe_follows_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (pin_oe_o == $past(pin_dir_out_i)))
        else $error("pin enable does not follow direction");
    a_dir_gates_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (pin_out_o == ($past(level_ff) & $past(pin_dir_out_i))))
        else $error("pin level not gated by direction");
    a_pins_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_pins) |=> (wb_dat_o[7:6] == 2'h0))
        else $error("reserved pin bits read nonzero");
endmodule

// [dv/opr_host.sv]
// Host model: classic Wishbone master that writes and reads device registers.
// Assumes a slave on the same clock.
`timescale 1ns/1ps
module opr_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [13:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    logic to_flag = 1'b0;
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // ==========================================================
    // Bus cycle
    // The bound on the wait stands in for a bus error, which this slave lacks.
    task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 50);
        r = dat_i;
        to_flag = (ack_i !== 1'b1);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// [dv/opr_regs_tb_top.sv]
// Testbench: random register traffic checked against a small behavioural model.
// Assumes the register slice answers every request with a single ack.
`timescale 1ns/1ps
module opr_regs_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, start, page, st_seen = 1'b0;
    logic u1 = 1'b0, u2 = 1'b0;
    logic [5:0] dir = 6'h00, pout, poe;
    logic [13:0] adr;
    logic [3:0] sel, s;
    logic [31:0] wdat, rdat, d, r;
    int seed = 51481, error_cnt = 0, cmp_count = 0, page_m = 0, lvl_m = 0;
    opr_host i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    opr_regs i_opr_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .unlock_one_ok_i(u1), .unlock_two_ok_i(u2), .pin_dir_out_i(dir),
        .prog_start_o(start), .prog_page_o(page), .pin_out_o(pout), .pin_oe_o(poe));
    initial forever #12.5 clk_i = ~clk_i;
    // The start pulse stands only in the ack cycle, so it is caught there.
    always @(posedge clk_i) if (ack) st_seen <= start;
    // ==========================================================
    // Shared tasks
    task automatic end_of_test;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] dd,
                       input logic [3:0] ss, output logic [31:0] rr);
        i_host.xfer(w, a, dd, ss, rr);
        if (i_host.to_flag) begin
            error_cnt++;
            $display("[ERR] %0t no ack", $time);
            end_of_test();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, opr_pkg::OPR_ADR_PROG_CTRL, 0, 4'hf, r); chk(r, 0);
        bus(0, opr_pkg::OPR_ADR_PIN_OUT, 0, 4'hf, r); chk(r, 0);
        repeat (60) begin
            d = $random(seed);
            s = 4'($random(seed));
            u1 <= 1'($random(seed));
            u2 <= 1'($random(seed));
            bus(1, opr_pkg::OPR_ADR_PROG_CTRL, d, s, r);
            chk(st_seen, d[0] & s[0] & u1 & u2);
            if (s[0]) page_m = d[1];
            chk(page, page_m);
            bus(0, opr_pkg::OPR_ADR_PROG_CTRL, 0, 4'hf, r);
            chk(r, page_m << 1);
            d = $random(seed);
            s = 4'($random(seed));
            dir <= 6'($random(seed));
            bus(1, opr_pkg::OPR_ADR_PIN_OUT, d, s, r);
            if (s[0]) lvl_m = d[5:0];
            bus(0, opr_pkg::OPR_ADR_PIN_OUT, 0, 4'hf, r);
            chk(r, lvl_m);
            chk(pout, lvl_m & dir);
            chk(poe, dir);
            bus(1, 14'h424, $random(seed), 4'hf, r);
            bus(0, 14'h424, 0, 4'hf, r);
            chk(r, 0);
        end
        end_of_test();
    end
endmodule
